// ==== common/see_params.svh ====
// Constants of the serial EEPROM two-wire write front end.
// Assumes a 50 MHz core clock; included by package and logic files.
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

`define SEE_CLK_MHZ          50
`define SEE_WRITE_TIME_US    100
`define SEE_WRITE_CYCLES     (`SEE_WRITE_TIME_US * `SEE_CLK_MHZ)
`define SEE_BUSY_W           24
`define SEE_ADDR_W           18
`define SEE_FAMILY           3'h5
`define SEE_TYPE_ID_PAGE     1'h1
`define SEE_BIT_SEL_CS       3
`define SEE_BIT_SEL_ID       4
`define SEE_BIT_SEL_RD       0
`define SEE_BIT_HI_LOCK      2
`define SEE_BIT_LOCK_DATA    1
`define SEE_BYTE_BITS        4'h8

`endif

// ==== common/see_pkg.sv ====
// Types of the serial EEPROM two-wire write front end.
// Assumes see_params.svh for widths.
`include "see_params.svh"

package see_pkg;

    typedef enum logic [6:0] {
        SEE_IDLE = 7'h01,
        SEE_SEL  = 7'h02,
        SEE_AHI  = 7'h04,
        SEE_ALO  = 7'h08,
        SEE_DATA = 7'h10,
        SEE_SKIP = 7'h20,
        SEE_BUSY = 7'h40
    } see_state_type;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [1:0] s3;
    } see_sync_type;

    typedef struct packed {
        see_state_type              st;
        logic [3:0]                 bits;
        logic [7:0]                 shreg;
        logic                       ack_ph;
        logic                       oe;
        logic [7:0]                 sel;
        logic [7:0]                 ahi;
        logic [7:0]                 inpage;
        logic [7:0]                 last;
        logic                       data_acked;
        logic                       wrote;
        logic                       lock_pend;
        logic                       locked;
        logic [`SEE_BUSY_W-1:0]     busy_cnt;
        logic [`SEE_ADDR_W-1:0]     ptr;
        logic                       latch_we;
        logic                       latch_id;
        logic [`SEE_ADDR_W-1:0]     latch_addr;
        logic [7:0]                 latch_data;
        logic                       commit;
    } see_core_type;

endpackage : see_pkg

// ==== logic/see_pin_sync.sv ====
// Pin synchroniser and bus condition finder for the two-wire slave.
// Assumes asynchronous pins; all outputs are on the clk_i domain.
`timescale 1ns/100ps
`default_nettype none

module see_pin_sync
    import see_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic scl_pin_i,
    input  wire logic sda_pin_i,
    input  wire logic cs_pin_i,
    input  wire logic wp_pin_i,
    output logic      scl_rise_o,
    output logic      scl_fall_o,
    output logic      start_o,
    output logic      stop_o,
    output logic      sda_o,
    output logic      cs_o,
    output logic      wp_o
);

    see_sync_type r;
    see_sync_type r_nxt;

    always_comb begin
        r_nxt    = r;
        r_nxt.s1 = {wp_pin_i, cs_pin_i, sda_pin_i, scl_pin_i};
        r_nxt.s2 = r.s1;
        r_nxt.s3 = r.s2[1:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{s1: 4'hf, s2: 4'hf, s3: 2'h3};
        end else begin
            r <= r_nxt;
        end
    end

    // Edges and conditions use only the second and third stages
    assign scl_rise_o = r.s2[0] & ~r.s3[0];
    assign scl_fall_o = ~r.s2[0] & r.s3[0];
    assign start_o    = r.s2[0] & r.s3[0] & r.s3[1] & ~r.s2[1];
    assign stop_o     = r.s2[0] & r.s3[0] & ~r.s3[1] & r.s2[1];
    assign sda_o      = r.s2[1];
    assign cs_o       = r.s2[2];
    assign wp_o       = r.s2[3];

endmodule // see_pin_sync

`default_nettype wire

// ==== logic/see_write_slave.sv ====
// Two-wire slave write front end of a serial EEPROM.
// Assumes a bus master drives the clock line; memory sits outside.
`timescale 1ns/100ps
`default_nettype none
`include "see_params.svh"

module see_write_slave
    import see_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SEE_WRITE_CYCLES
)
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_o,
    input  wire logic                   chip_select_strap_i,
    input  wire logic                   write_protect_input_i,
    output logic                        busy_o,
    output logic                        id_locked_o,
    output logic [`SEE_ADDR_W-1:0]      addr_ptr_o,
    output logic                        latch_we_o,
    output logic                        latch_id_o,
    output logic [`SEE_ADDR_W-1:0]      latch_addr_o,
    output logic [7:0]                  latch_data_o,
    output logic [`SEE_ADDR_W-3:0]      latch_group_o,
    output logic                        commit_o
);

    localparam logic [`SEE_BUSY_W-1:0] BUSY_LOAD =
        `SEE_BUSY_W'(WRITE_CYCLES);

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic sda_s;
    logic cs_s;
    logic wp_s;

    see_pin_sync u_sync (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .scl_pin_i  (scl_i),
        .sda_pin_i  (sda_i),
        .cs_pin_i   (chip_select_strap_i),
        .wp_pin_i   (write_protect_input_i),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_cond),
        .stop_o     (stop_cond),
        .sda_o      (sda_s),
        .cs_o       (cs_s),
        .wp_o       (wp_s)
    );

    see_core_type r;
    see_core_type r_nxt;

    logic                   sel_match;
    logic                   byte_ok;
    logic                   is_id;
    logic                   is_lock;
    logic [9:0]             page;

    always_comb begin
        r_nxt          = r;
        r_nxt.latch_we = 1'b0;
        r_nxt.commit   = 1'b0;
        is_id          = r.sel[`SEE_BIT_SEL_ID] == `SEE_TYPE_ID_PAGE;
        is_lock        = is_id & r.ahi[`SEE_BIT_HI_LOCK];
        page           = {r.sel[2:1], r.ahi};
        // Select decode: family, strap compare
        sel_match = (r.shreg[7:5] == `SEE_FAMILY) &&
                    (r.shreg[`SEE_BIT_SEL_CS] == cs_s);
        // Data byte is accepted only unprotected and, on the identification page, not locked
        byte_ok   = ~wp_s & ~(is_id & r.locked);
        if (r.st == SEE_BUSY) begin
            // Output released and bus ignored while writing
            r_nxt.oe = 1'b0;
            if (r.busy_cnt <= `SEE_BUSY_W'(1)) begin
                r_nxt.busy_cnt = '0;
                r_nxt.st       = SEE_IDLE;
                if (r.lock_pend) begin
                    r_nxt.locked    = 1'b1;
                    r_nxt.lock_pend = 1'b0;
                end else begin
                    r_nxt.ptr = is_id ?
                        {10'h000, r.last + 8'h01} :
                        {page, r.last + 8'h01};
                end
            end else begin
                r_nxt.busy_cnt = r.busy_cnt - `SEE_BUSY_W'(1);
            end
        end else if (start_cond) begin
            // Any start outside the write cycle restarts the command
            r_nxt.st         = SEE_SEL;
            r_nxt.bits       = 4'h0;
            r_nxt.ack_ph     = 1'b0;
            r_nxt.oe         = 1'b0;
            r_nxt.data_acked = 1'b0;
            r_nxt.wrote      = 1'b0;
            r_nxt.lock_pend  = 1'b0;
        end else if (stop_cond) begin
            r_nxt.oe     = 1'b0;
            r_nxt.ack_ph = 1'b0;
            if (r.st == SEE_DATA && r.data_acked && r.wrote) begin
                r_nxt.commit   = 1'b1;
                r_nxt.busy_cnt = BUSY_LOAD;
                r_nxt.st       = SEE_BUSY;
            end else begin
                r_nxt.st        = SEE_IDLE;
                r_nxt.lock_pend = 1'b0;
            end
        end else begin
            case (r.st)
                SEE_SEL, SEE_AHI, SEE_ALO, SEE_DATA: begin
                    if (scl_rise && !r.ack_ph) begin
                        r_nxt.shreg      = {r.shreg[6:0], sda_s};
                        r_nxt.bits       = r.bits + 4'h1;
                        // Flag lives through the clock rise of a slot ten stop
                        r_nxt.data_acked = r.data_acked & (r.bits == 4'h0);
                    end
                    if (scl_fall && !r.ack_ph &&
                        r.bits == `SEE_BYTE_BITS) begin
                        r_nxt.ack_ph = 1'b1;
                        case (r.st)
                            SEE_SEL: begin
                                if (sel_match) begin
                                    r_nxt.sel = r.shreg;
                                    r_nxt.oe  = 1'b1;
                                end else begin
                                    r_nxt.ack_ph = 1'b0;
                                    r_nxt.st     = SEE_IDLE;
                                end
                            end
                            SEE_AHI: begin
                                r_nxt.ahi = r.shreg;
                                r_nxt.oe  = 1'b1;
                            end
                            SEE_ALO: begin
                                r_nxt.inpage = r.shreg;
                                r_nxt.oe     = 1'b1;
                            end
                            default: begin
                                r_nxt.oe = byte_ok;
                                if (byte_ok && is_lock) begin
                                    r_nxt.wrote = 1'b1;
                                    r_nxt.lock_pend =
                                        r.shreg[`SEE_BIT_LOCK_DATA];
                                end else if (byte_ok) begin
                                    // Byte goes to the internal latches
                                    r_nxt.latch_we   = 1'b1;
                                    r_nxt.latch_id   = is_id;
                                    r_nxt.latch_addr = is_id ?
                                        {10'h000, r.inpage} :
                                        {page, r.inpage};
                                    r_nxt.latch_data = r.shreg;
                                    r_nxt.last       = r.inpage;
                                    // Eight-bit counter wraps in page
                                    r_nxt.inpage = r.inpage + 8'h01;
                                    r_nxt.wrote  = 1'b1;
                                end
                            end
                        endcase
                    end else if (scl_fall && r.ack_ph) begin
                        // Ninth clock over: release the line
                        r_nxt.ack_ph = 1'b0;
                        r_nxt.oe     = 1'b0;
                        r_nxt.bits   = 4'h0;
                        case (r.st)
                            SEE_SEL: begin
                                r_nxt.st = r.sel[`SEE_BIT_SEL_RD] ?
                                    SEE_SKIP : SEE_AHI;
                            end
                            SEE_AHI: r_nxt.st = SEE_ALO;
                            SEE_ALO: r_nxt.st = SEE_DATA;
                            default: r_nxt.data_acked = r.oe;
                        endcase
                    end
                end
                default: begin
                    r_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{st: SEE_IDLE, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    assign sda_o         = 1'b0;
    assign sda_oe_o      = r.oe;
    assign busy_o        = r.st == SEE_BUSY;
    assign id_locked_o   = r.locked;
    assign addr_ptr_o    = r.ptr;
    assign latch_we_o    = r.latch_we;
    assign latch_id_o    = r.latch_id;
    assign latch_addr_o  = r.latch_addr;
    assign latch_data_o  = r.latch_data;
    // Whole four-byte correction group is rewritten with each byte
    assign latch_group_o = r.latch_addr[`SEE_ADDR_W-1:2];
    assign commit_o      = r.commit;

    // Helper logic for the checks below
    logic [`SEE_BUSY_W-1:0] chk_busy;
    logic [8:0]             chk_prev;
    logic [9:0]             chk_page;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_busy <= '0;
            chk_prev <= '0;
            chk_page <= '0;
        end else begin
            chk_busy <= busy_o ? chk_busy + `SEE_BUSY_W'(1) : '0;
            if (start_cond && !busy_o) begin
                chk_prev <= '0;
            end else if (latch_we_o) begin
                chk_prev <= {1'b1, latch_addr_o[7:0]};
                chk_page <= latch_addr_o[17:8];
            end
        end
    end

    busy_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o |-> !sda_oe_o)
        else $error("line driven during write cycle");

    busy_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> chk_busy == `SEE_BUSY_W'(WRITE_CYCLES))
        else $error("write cycle length wrong");

    commit_slot_a: assert property (@(posedge clk_i) disable iff (rst_i)
        commit_o |-> busy_o && $past(r.data_acked) && $past(stop_cond))
        else $error("write started outside tenth slot");

    protect_nack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        latch_we_o |-> !$past(wp_s) && sda_oe_o)
        else $error("protected byte latched");

    strap_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sda_oe_o) && $past(r.st) == SEE_SEL |->
            r.sel[`SEE_BIT_SEL_CS] == $past(cs_s) && r.sel[7:5] == `SEE_FAMILY)
        else $error("select acknowledged on mismatch");

    page_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        latch_we_o && chk_prev[8] && !latch_id_o |->
            latch_addr_o[7:0] == chk_prev[7:0] + 8'h01 &&
            latch_addr_o[17:8] == chk_page)
        else $error("in-page address did not advance");

    start_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_cond && !busy_o |=> r.st == SEE_SEL && !sda_oe_o)
        else $error("start did not restart command");

    lock_nack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        latch_we_o && latch_id_o |-> !id_locked_o)
        else $error("locked page written");

    ack_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sda_oe_o && scl_fall && r.ack_ph |=> !sda_oe_o)
        else $error("acknowledge held past ninth clock");

    data_nack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(r.ack_ph) && r.st == SEE_DATA && $past(wp_s) |->
            !sda_oe_o)
        else $error("protected data byte acknowledged");

    addr_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(r.ack_ph) && (r.st == SEE_AHI || r.st == SEE_ALO) |->
            sda_oe_o)
        else $error("address byte not acknowledged");

    read_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_fall && r.ack_ph && r.st == SEE_SEL &&
            r.sel[`SEE_BIT_SEL_RD] |=> r.st == SEE_SKIP && !sda_oe_o)
        else $error("read select not released");

    sel_reject_a: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_fall && !r.ack_ph && r.st == SEE_SEL && r.bits == `SEE_BYTE_BITS &&
            r.shreg[`SEE_BIT_SEL_CS] != cs_s |=> r.st == SEE_IDLE && !sda_oe_o)
        else $error("mismatched select not released");

    busy_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o && r.busy_cnt > `SEE_BUSY_W'(1) |=>
            busy_o && r.busy_cnt == $past(r.busy_cnt) - `SEE_BUSY_W'(1))
        else $error("write cycle left early");

    ptr_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) && chk_prev[8] |->
            addr_ptr_o[7:0] == chk_prev[7:0] + 8'h01)
        else $error("address counter not past last byte");

    id_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        latch_we_o && latch_id_o |->
            latch_addr_o[17:8] == 10'h000 && !r.ahi[`SEE_BIT_HI_LOCK])
        else $error("identification byte address wrong");

    stop_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_cond && !busy_o && !(r.st == SEE_DATA && r.data_acked) |=>
            !commit_o && !busy_o)
        else $error("write started by stop in wrong slot");

    lock_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(id_locked_o) |-> $past(busy_o) && !busy_o)
        else $error("page locked outside write cycle end");

endmodule // see_write_slave

`default_nettype wire

// ==== test/see_bus_master.sv ====
// Two-wire bus master model that drives the clock line and pulls data low.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/100ps
`default_nettype none

module see_bus_master (
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    localparam time Q = 40ns;
    localparam time T = 80ns;

    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end

    // Start, also as a repeated start
    task automatic start();
        sda_low_o <= 1'h0;
        #T scl_o <= 1'h1;
        #T sda_low_o <= 1'h1;  // Data falls while clock high
        #T scl_o <= 1'h0;
    endtask

    task automatic stop();
        sda_low_o <= 1'h1;
        #T scl_o <= 1'h1;
        #T sda_low_o <= 1'h0;  // Data rises while clock high
        #T;
    endtask

    // Eight bits MSB first, then the ninth clock with data released
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #Q sda_low_o <= ~b[i];  // Changed with clock low
            #Q scl_o <= 1'h1;
            #T scl_o <= 1'h0;
        end
        #Q sda_low_o <= 1'h0;  // Release for the ninth bit
        #Q scl_o <= 1'h1;
        #Q ack = ~sda_i;
        #Q scl_o <= 1'h0;
    endtask
endmodule // see_bus_master

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the two-wire write front end.
// Assumes see_pkg and the bus master model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "see_params.svh"

module tb
    import see_pkg::*;
;
    localparam int WCYC = 40;
    logic                   clk_i;
    logic                   rst_i;
    logic                   strap;
    logic                   wp;
    wire logic              scl;
    wire logic              sda_low;
    logic                   sda_o;
    logic                   sda_oe_o;
    logic                   busy_o;
    logic                   id_locked_o;
    logic                   latch_we_o;
    logic                   latch_id_o;
    logic                   commit_o;
    logic [`SEE_ADDR_W-1:0] addr_ptr_o;
    logic [`SEE_ADDR_W-1:0] latch_addr_o;
    logic [7:0]             latch_data_o;
    logic [`SEE_ADDR_W-3:0] latch_group_o;
    logic [26:0]            lq[$];
    int                     err_count = 0;
    int                     samples_checked = 0;
    int                     n_commit = 0;
    int                     busy_cyc = 0;
    wire logic              sda = ~(sda_low | (sda_oe_o & ~sda_o));

    see_bus_master master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

    see_write_slave #(.WRITE_CYCLES(WCYC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_strap_i(strap),
        .write_protect_input_i(wp), .busy_o(busy_o),
        .id_locked_o(id_locked_o), .addr_ptr_o(addr_ptr_o),
        .latch_we_o(latch_we_o), .latch_id_o(latch_id_o),
        .latch_addr_o(latch_addr_o), .latch_data_o(latch_data_o),
        .latch_group_o(latch_group_o), .commit_o(commit_o)
    );

    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (latch_we_o === 1'h1) begin
            lq.push_back({latch_id_o, latch_addr_o, latch_data_o});
            chk(latch_group_o, latch_addr_o[17:2]);
        end
        if (commit_o === 1'h1) n_commit++;
        if (busy_o === 1'h1) busy_cyc++;
    end

    task automatic tx(input logic [7:0] b, input logic exp);
        logic a;
        master.put_byte(b, a);
        chk(a, exp);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (8) @(posedge clk_i);
        while (busy_o !== 1'h0) begin
            @(posedge clk_i);
            n++;
            if (n > 500) begin
                err_count++;
                wrap_up();
            end
        end
    endtask

    task automatic fresh();
        lq.delete();
        n_commit = 0;
        busy_cyc = 0;
    endtask

    task automatic t_byte();
        fresh();
        master.start();
        tx(8'hAE, 1'h1);
        tx(8'h12, 1'h1);
        tx(8'h34, 1'h1);
        tx(8'h5A, 1'h1);
        master.stop();
        master.start();
        tx(8'hAE, 1'h0);
        wait_idle();
        master.start();
        tx(8'hAE, 1'h1);
        master.stop();
        chk(n_commit, 1);
        chk(busy_cyc, WCYC);
        chk(lq.size(), 1);
        chk(lq[0], {1'h0, 18'h3_1234, 8'h5A});
        chk(addr_ptr_o, 18'h3_1235);
        $display("Test byte write done");
    endtask

    task automatic t_select();
        master.start();
        tx(8'hA6, 1'h0);
        tx(8'h00, 1'h0);
        master.start();
        tx(8'h2E, 1'h0);
        master.start();
        tx(8'hA9, 1'h1);
        master.stop();
        @(posedge clk_i);
        strap <= 1'h0;
        master.start();
        tx(8'hA0, 1'h1);
        master.stop();
        @(posedge clk_i);
        strap <= 1'h1;
        $display("Test select decode done");
    endtask

    task automatic t_protect();
        fresh();
        @(posedge clk_i);
        wp <= 1'h1;
        master.start();
        tx(8'hA8, 1'h1);
        tx(8'h00, 1'h1);
        tx(8'h10, 1'h1);
        tx(8'h77, 1'h0);
        tx(8'h78, 1'h0);
        master.stop();
        repeat (10) @(posedge clk_i);
        chk(n_commit, 0);
        chk(lq.size(), 0);
        wp <= 1'h0;
        $display("Test write protect done");
    endtask

    task automatic t_page();
        fresh();
        master.start();
        tx(8'hA8, 1'h1);
        tx(8'h05, 1'h1);
        tx(8'hFE, 1'h1);
        tx(8'h11, 1'h1);
        tx(8'h22, 1'h1);
        tx(8'h33, 1'h1);
        master.stop();
        wait_idle();
        chk(n_commit, 1);
        chk(lq[0], {1'h0, 18'h0_05FE, 8'h11});
        chk(lq[1], {1'h0, 18'h0_05FF, 8'h22});
        chk(lq[2], {1'h0, 18'h0_0500, 8'h33});
        chk(addr_ptr_o, 18'h0_0501);
        $display("Test page write done");
    endtask

    task automatic t_abort();
        fresh();
        master.start();
        tx(8'hA8, 1'h1);
        tx(8'h07, 1'h1);
        master.start();
        tx(8'hA8, 1'h1);
        tx(8'h01, 1'h1);
        tx(8'h02, 1'h1);
        tx(8'h44, 1'h1);
        master.stop();
        wait_idle();
        chk(lq[0], {1'h0, 18'h0_0102, 8'h44});
        fresh();
        master.start();
        tx(8'hA8, 1'h1);
        tx(8'h01, 1'h1);
        tx(8'h02, 1'h1);
        master.stop();
        repeat (10) @(posedge clk_i);
        chk(n_commit, 0);
        $display("Test abort and stop slot done");
    endtask

    task automatic t_idpage();
        fresh();
        master.start();
        tx(8'hB8, 1'h1);
        tx(8'hFB, 1'h1);
        tx(8'h40, 1'h1);
        tx(8'hC3, 1'h1);
        master.stop();
        wait_idle();
        chk(lq[0], {1'h1, 18'h0_0040, 8'hC3});
        chk(addr_ptr_o, 18'h0_0041);
        master.start();
        tx(8'hB8, 1'h1);
        tx(8'h04, 1'h1);
        tx(8'h00, 1'h1);
        tx(8'h02, 1'h1);
        master.stop();
        wait_idle();
        chk(id_locked_o, 1'h1);
        fresh();
        master.start();
        tx(8'hB8, 1'h1);
        tx(8'h00, 1'h1);
        tx(8'h40, 1'h1);
        tx(8'h55, 1'h0);
        master.stop();
        repeat (10) @(posedge clk_i);
        chk(lq.size(), 0);
        chk(n_commit, 0);
        $display("Test identification page done");
    endtask

    initial begin
        rst_i = 1'h1;
        strap = 1'h1;
        wp = 1'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        t_byte();
        t_select();
        t_protect();
        t_page();
        t_abort();
        t_idpage();
        wrap_up();
    end
endmodule // tb

`default_nettype wire
